// [dom_pkg.sv]
// Package with register map, field layout and encodings of the diagnostic output mux.
package dom_pkg;

    localparam logic [11:0] ctrl_offset      = 12'h000;
    localparam logic [11:0] sel_offset       = 12'h004;
    localparam logic [11:0] status_offset    = 12'h008;

    localparam int          cfg_lsb          = 0;
    localparam int          enable_bit       = 2;
    localparam int          forced_level_bit = 3;
    localparam int          intcon_lsb       = 4;

    localparam logic [1:0]  cfg_reset        = 2'h0;
    localparam logic        enable_reset     = 1'b0;
    localparam logic        forced_reset     = 1'b0;
    localparam logic [2:0]  intcon_reset     = 3'h0;
    localparam logic [7:0]  sel_reset        = 8'h00;

    typedef enum logic [1:0] {
        DOM_FORCED  = 2'b00,
        DOM_DIGITAL = 2'b01,
        DOM_ANALOG  = 2'b10,
        DOM_INTCON  = 2'b11
    } dom_mode_t;

    typedef enum logic [1:0] {
        DOM_DRV_OFF = 2'b00,
        DOM_DRV_DIG = 2'b01,
        DOM_DRV_ANA = 2'b10
    } dom_drv_t;

    // Analog select codes.
    localparam logic [7:0]  ana_mon_input    = 8'h01;
    localparam logic [7:0]  ana_reg_input    = 8'h02;
    localparam logic [7:0]  ana_reg_ref      = 8'h03;
    localparam logic [7:0]  ana_mon_ref      = 8'h04;
    localparam logic [7:0]  ana_reg_supply   = 8'h05;
    localparam logic [7:0]  ana_mon_supply   = 8'h06;

    // Digital groups.
    localparam logic [2:0]  grp_supply       = 3'h0;
    localparam logic [2:0]  grp_clock        = 3'h1;
    localparam logic [2:0]  grp_protect      = 3'h2;
    localparam int          dig_count        = 48;

endpackage

// [dom_sel_if.sv]
// Interface that carries the routing choice from the top to the selector.
`timescale 1ns/100ps
interface dom_sel_if;
    logic [1:0]  mode;
    logic [7:0]  sel;
    logic [2:0]  intcon;
    logic        forced;
    logic        pin_level;
    logic [2:0]  ana_channel;
    modport top (output mode, output sel, output intcon, output forced,
                 input pin_level, input ana_channel);
    modport pick (input mode, input sel, input intcon, input forced,
                  output pin_level, output ana_channel);
endinterface

// [dom_selector.sv]
// Combinational selector that picks the digital level and analog channel.
`timescale 1ns/100ps
module dom_selector
    import dom_pkg::*;
(
    input  wire logic [dig_count-1:0] dig_sig,
    input  wire logic [3:0]           intcon_in,
    dom_sel_if.pick                   bus
);
    // Reserved slots inside groups 0..2 are masked, so a stray input never reaches the pin.
    localparam logic [dig_count-1:0] dig_used = 48'hfffe_00bf_9f82;
    logic [5:0] idx;

    always_comb begin
        idx = {bus.sel[5:4], bus.sel[3:0]};
        bus.pin_level = 1'b0;
        bus.ana_channel = 3'h0;
        case (bus.mode)
            DOM_FORCED: begin
                bus.pin_level = bus.forced;
            end
            DOM_DIGITAL: begin
                // Groups above 010b are reserved and read as low.
                if (bus.sel[6:4] <= grp_protect) begin
                    bus.pin_level = dig_sig[idx] & dig_used[idx];
                end else begin
                    bus.pin_level = 1'b0;
                end
            end
            DOM_INTCON: begin
                bus.pin_level = (bus.intcon < 3'h4) ? intcon_in[bus.intcon[1:0]] : 1'b0;
            end
            DOM_ANALOG: begin
                // Codes 0 and 0x07..0xff leave channel 0, meaning the buffer stays off.
                if (bus.sel >= ana_mon_input && bus.sel <= ana_mon_supply) begin
                    bus.ana_channel = bus.sel[2:0];
                end
            end
            default: begin
                bus.pin_level = 1'b0;
            end
        endcase
    end
endmodule

// [dom_top.sv]
// Top of the diagnostic output mux with its register bus.
// Functional notes
// - Config 10b routes the selected analog channel to the pin.
// - In analog mode the digital driver stays high impedance.
// - Config 01b routes the selected digital signal to the pin.
// - In digital mode the analog buffer stays high impedance.
// - Analog 0x01 monitor input supply, 0x02 regulator input supply, divided by 20.
// - Analog 0x03 regulator reference, 0x04 monitor reference, undivided.
// - Analog 0x05 regulator internal supply, 0x06 monitor internal supply, by 4.375.
// - Analog select zero and 0x07..0xff keep the analog driver off.
// - Digital select bits 6:4 group, 3:0 channel; D0.1 internal regulator undervoltage.
// - Group 1 channels 0, 2, 3: sync out, PLL, sync in clocks.
// - Group 1 channel 1 outputs the internal system clock.
// - Group 1 channels 4, 5, 7: first buck, second buck, boost switch clocks.
// - Group 2 channels 1..3: first buck high side, low side, sink limits.
// - Group 2 channel 4 first buck overvoltage, channel 5 overtemperature.
// - With the output enable cleared the pin is high impedance.
// - Config 00b drives the pin to the software forced level bit.
// - Config 11b reflects the interconnect input chosen by a three-bit field.
`timescale 1ns/100ps
module dom_top
    import dom_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [dig_count-1:0] dig_sig,
    input  wire logic [3:0]           intcon_pins,
    output logic                      diagnostic_output_pin_o,
    output logic                      diagnostic_output_pin_oe_n,
    output logic                      analog_probe_buffer_en,
    output logic      [2:0]           analog_probe_channel
);
    logic [1:0]           output_source_config_reg;
    logic                 probe_output_enable_reg;
    logic                 forced_pin_level_reg;
    logic [2:0]           interconnect_input_select_reg;
    logic [7:0]           probe_channel_select_reg;
    logic [dig_count-1:0] dig_meta_reg;
    logic [dig_count-1:0] dig_sync_reg;
    logic [3:0]           pin_meta_reg;
    logic [3:0]           pin_sync_reg;
    dom_drv_t             drv_reg;
    dom_drv_t             drv_next;
    logic                 wr_en;
    logic                 rd_en;
    logic                 mapped;
    logic                 want_analog;
    dom_sel_if            sel_bus ();

    assign wr_en  = psel && penable && pwrite && pready;
    assign rd_en  = psel && penable && !pwrite && pready;
    assign mapped = (paddr == ctrl_offset) || (paddr == sel_offset) ||
                    (paddr == status_offset);

    // Every access completes in its first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_source_config_reg      <= cfg_reset;
            probe_output_enable_reg       <= enable_reset;
            forced_pin_level_reg          <= forced_reset;
            interconnect_input_select_reg <= intcon_reset;
        end else if (wr_en && paddr == ctrl_offset && pstrb[0]) begin
            output_source_config_reg      <= pwdata[cfg_lsb+1:cfg_lsb];
            probe_output_enable_reg       <= pwdata[enable_bit];
            forced_pin_level_reg          <= pwdata[forced_level_bit];
            interconnect_input_select_reg <= pwdata[intcon_lsb+2:intcon_lsb];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            probe_channel_select_reg <= sel_reset;
        end else if (wr_en && paddr == sel_offset && pstrb[0]) begin
            probe_channel_select_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                ctrl_offset:   prdata <= {25'h0, interconnect_input_select_reg,
                                          forced_pin_level_reg, probe_output_enable_reg,
                                          output_source_config_reg};
                sel_offset:    prdata <= {24'h0, probe_channel_select_reg};
                status_offset: prdata <= {27'h0, analog_probe_channel,
                                          analog_probe_buffer_en,
                                          !diagnostic_output_pin_oe_n};
                default:       prdata <= 32'h0000_0000;
            endcase
        end else if (!rd_en) begin
            prdata <= prdata;
        end
    end

    // Probed signals come from other domains, so each passes two flops first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dig_meta_reg <= '0;
            dig_sync_reg <= '0;
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            dig_meta_reg <= dig_sig;
            dig_sync_reg <= dig_meta_reg;
            pin_meta_reg <= intcon_pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign sel_bus.mode   = output_source_config_reg;
    assign sel_bus.sel    = probe_channel_select_reg;
    assign sel_bus.intcon = interconnect_input_select_reg;
    assign sel_bus.forced = forced_pin_level_reg;

    dom_selector i_dom_selector (
        .dig_sig   (dig_sync_reg),
        .intcon_in (pin_sync_reg),
        .bus       (sel_bus)
    );

    assign want_analog = output_source_config_reg == DOM_ANALOG &&
                         sel_bus.ana_channel != 3'h0;

    // A change between analog and digital passes one cycle with both off,
    // so the two buffers never fight on the pin.
    always_comb begin
        drv_next = DOM_DRV_OFF;
        if (!probe_output_enable_reg) begin
            drv_next = DOM_DRV_OFF;
        end else if (want_analog) begin
            drv_next = (drv_reg == DOM_DRV_DIG) ? DOM_DRV_OFF : DOM_DRV_ANA;
        end else if (output_source_config_reg != DOM_ANALOG) begin
            drv_next = (drv_reg == DOM_DRV_ANA) ? DOM_DRV_OFF : DOM_DRV_DIG;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_reg <= DOM_DRV_OFF;
        end else begin
            drv_reg <= drv_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diagnostic_output_pin_oe_n <= 1'b1;
            diagnostic_output_pin_o    <= 1'b0;
            analog_probe_buffer_en     <= 1'b0;
            analog_probe_channel       <= 3'h0;
        end else begin
            diagnostic_output_pin_oe_n <= (drv_next != DOM_DRV_DIG);
            diagnostic_output_pin_o    <= (drv_next == DOM_DRV_DIG) ? sel_bus.pin_level : 1'b0;
            analog_probe_buffer_en     <= (drv_next == DOM_DRV_ANA);
            analog_probe_channel       <= (drv_next == DOM_DRV_ANA) ? sel_bus.ana_channel
                                                                    : 3'h0;
        end
    end
endmodule

// [dom_mcu_model.sv]
// Model of the controller input pin that watches the diagnostic output.
`timescale 1ns/100ps
module dom_mcu_model (
    input  wire logic pclk,
    input  wire logic pin_o,
    input  wire logic oe_n,
    output logic      level
);
    initial level = 1'b0;
    // A released pin has no pull, so the seen level toggles and cannot pass by luck.
    always @(posedge pclk) begin
        level <= oe_n ? ~level : pin_o;
    end
endmodule

// [dom_top_chk.sv]
// Checker of the diagnostic mux port behaviour.
`timescale 1ns/100ps
module dom_chk
    import dom_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        diagnostic_output_pin_oe_n,
    input wire logic        analog_probe_buffer_en,
    input wire logic [2:0]  analog_probe_channel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic oen;
    logic an;
    assign wr = psel && penable && pready && pwrite && pstrb[0] && paddr == ctrl_offset;
    assign oen = diagnostic_output_pin_oe_n;
    assign an = analog_probe_buffer_en;
    chk_drv_exclusive: assert property (!(an && !oen))
        else $error("both drivers on");
    chk_gap_to_dig: assert property ($fell(oen) |-> !$past(an))
        else $error("digital on without gap");
    chk_gap_to_ana: assert property ($rose(an) |-> $past(oen))
        else $error("analog on without gap");
    chk_chan_valid: assert property (an |-> analog_probe_channel inside {[1:6]})
        else $error("bad analog channel");
    chk_chan_off: assert property (!an |-> analog_probe_channel == 3'h0)
        else $error("channel without driver");
    chk_ana_mode: assert property (wr && pwdata[1:0] == 2'b10 |=> ##1 oen)
        else $error("digital on in analog mode");
    chk_dig_mode: assert property (wr && pwdata[1:0] == 2'b01 |=> ##1 !an)
        else $error("analog on in digital mode");
    chk_enable_off: assert property (wr && !pwdata[2] |=> ##1 (oen && !an))
        else $error("pin driven while disabled");
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind dom_top dom_chk i_dom_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .pslverr, .diagnostic_output_pin_oe_n, .analog_probe_buffer_en,
    .analog_probe_channel);

// [tb_dom_top.sv]
// Testbench of the diagnostic output mux.
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tb_dom_top;
    import dom_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  pstrb = 4'hf, intcon_pins = 4'h0;
    logic [47:0] dig_sig = 48'h0;
    logic        pready, pslverr, rerr, pin_o, oe_n, an_en, level, on;
    logic [2:0]  an_ch;
    logic [7:0]  s;
    int          fail_count = 0, check_count = 0, i;
    localparam logic [7:0] dcode [13] = '{8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h17, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
    always #5 pclk = ~pclk;
    dom_top i_dom_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .dig_sig, .intcon_pins, .diagnostic_output_pin_o(pin_o),
        .diagnostic_output_pin_oe_n(oe_n), .analog_probe_buffer_en(an_en),
        .analog_probe_channel(an_ch));
    dom_mcu_model i_dom_mcu_model (.pclk, .pin_o, .oe_n, .level);
    task print_verdict;
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Probe inputs need two sync flops, the output flop and the model's sample.
    task settle;
        repeat (5) @(posedge pclk);
    endtask
    task run_dig(input logic [7:0] sl, input logic [47:0] d, input logic e);
        apb(1'b1, sel_offset, {24'h0, sl});
        dig_sig <= d;
        settle;
        `CHK("pin", e, level)
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("oe_n", 1'b1, oe_n)
        apb(1'b0, ctrl_offset, 32'h0);
        `CHK("ctrl", 32'h0, rdat)
        apb(1'b0, sel_offset, 32'h0);
        `CHK("sel", 32'h0, rdat)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("err", 1'b1, rerr)
        `CHK("rd", 32'h0, rdat)
        apb(1'b1, ctrl_offset, 32'h6);
        apb(1'b0, ctrl_offset, 32'h0);
        `CHK("ctrl", 32'h6, rdat)
        pstrb <= 4'he;
        apb(1'b1, ctrl_offset, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, ctrl_offset, 32'h0);
        `CHK("ctrl_strb", 32'h6, rdat)
        for (i = 0; i < 10; i++) begin
            s = (i < 9) ? 8'(i) : 8'hff;
            apb(1'b1, sel_offset, {24'h0, s});
            settle;
            `CHK("ana_en", s >= 8'h01 && s <= 8'h06, an_en)
            `CHK("ana_ch", (s >= 8'h01 && s <= 8'h06) ? s[2:0] : 3'h0, an_ch)
            `CHK("oe_n", 1'b1, oe_n)
            on = s >= 8'h01 && s <= 8'h06;
            apb(1'b0, status_offset, 32'h0);
            `CHK("status", ({27'h0, on ? s[2:0] : 3'h0, on, 1'b0}), rdat)
        end
        apb(1'b1, ctrl_offset, 32'h5);
        for (i = 0; i < 13; i++) begin
            run_dig(dcode[i], 48'h1 << dcode[i][5:0], 1'b1);
            run_dig(dcode[i], ~(48'h1 << dcode[i][5:0]), 1'b0);
            `CHK("ana_en", 1'b0, an_en)
        end
        run_dig(8'h31, {48{1'b1}}, 1'b0);
        run_dig(8'h7f, {48{1'b1}}, 1'b0);
        run_dig(8'h00, {48{1'b1}}, 1'b0);
        run_dig(8'h16, {48{1'b1}}, 1'b0);
        apb(1'b1, sel_offset, 32'h1);
        apb(1'b1, ctrl_offset, 32'h6);
        repeat (2) @(posedge pclk);
        `CHK("gap", 2'b01, {an_en, oe_n})
        @(posedge pclk);
        `CHK("to_ana", 2'b11, {an_en, oe_n})
        apb(1'b1, ctrl_offset, 32'h5);
        repeat (2) @(posedge pclk);
        `CHK("gap", 2'b01, {an_en, oe_n})
        @(posedge pclk);
        `CHK("to_dig", 2'b00, {an_en, oe_n})
        apb(1'b0, status_offset, 32'h0);
        `CHK("status", 32'h1, rdat)
        dig_sig <= 48'h0;
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ctrl_offset, 32'(i));
            settle;
            `CHK("oe_n", 1'b1, oe_n)
            `CHK("ana_en", 1'b0, an_en)
        end
        apb(1'b1, ctrl_offset, 32'h4);
        settle;
        `CHK("forced", 1'b0, level)
        apb(1'b1, ctrl_offset, 32'hc);
        settle;
        `CHK("forced", 1'b1, level)
        intcon_pins <= 4'h6;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, ctrl_offset, 32'h7 | (i << 4));
            apb(1'b0, ctrl_offset, 32'h0);
            `CHK("ctrl", 32'h7 | (i << 4), rdat)
            settle;
            `CHK("intcon", (i < 4) ? intcon_pins[i[1:0]] : 1'b0, level)
        end
        print_verdict;
    end
endmodule
